//--- spf_analog_pin.sv
// One analog-capable pin: analog input to a converter or a port bit
`timescale 1ns/10ps
`include "spf_map.svh"
module spf_analog_pin (
  input  wire logic i_clock,
  input  wire logic i_rstn,
  input  wire logic i_analog_sel,
  input  wire logic i_port_dir,
  input  wire logic i_port_data,
  input  wire logic i_pin,
  output logic      o_analog_conn,
  output logic      o_pin_out,
  output logic      o_pin_oe_n,
  output logic      o_pin_in
);
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_analog_conn <= 1'h0;
      o_pin_out     <= 1'h0;
      o_pin_oe_n    <= 1'h1;
    end else begin
      o_analog_conn <= i_analog_sel;               // see R1 see R2
      o_pin_out     <= i_port_data;                // see R9
      o_pin_oe_n    <= i_analog_sel | ~i_port_dir; // see R3 see R9
    end
  end

  // Input always visible to port reads, even in analog mode
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_pin_in <= 1'h0;
    end else begin
      o_pin_in <= i_pin; // see R9
    end
  end
endmodule : spf_analog_pin

//--- spf_board.sv
// Board-side model of the levels seen on the shared pins
`timescale 1ns/10ps
module spf_board (
  input  wire logic [10:0] i_apin_out,
  input  wire logic [10:0] i_apin_oe_n,
  input  wire logic [5:0]  i_dpin_out,
  input  wire logic [5:0]  i_dpin_oe_n,
  input  wire logic [10:0] i_alevel,
  input  wire logic [5:0]  i_dlevel,
  output logic      [10:0] o_apin,
  output logic      [5:0]  o_dpin
);
  // Board level wins only where the chip's driver is off
  assign o_apin = (i_apin_oe_n & i_alevel) | (~i_apin_oe_n & i_apin_out);
  assign o_dpin = (i_dpin_oe_n & i_dlevel) | (~i_dpin_oe_n & i_dpin_out);
endmodule : spf_board

//--- spf_digital_pin.sv
// One digital shared pin: pulse output, sampled input or port bit
`timescale 1ns/10ps
module spf_digital_pin (
  input  wire logic i_clock,
  input  wire logic i_rstn,
  input  wire logic i_pulse_en,
  input  wire logic i_pulse_wave,
  input  wire logic i_in_en,
  input  wire logic i_port_dir,
  input  wire logic i_port_data,
  input  wire logic i_pin,
  output logic      o_pin_out,
  output logic      o_pin_oe_n,
  output logic      o_func_in,
  output logic      o_pin_in
);
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_pin_out  <= 1'h0;
      o_pin_oe_n <= 1'h1;
    end else if (i_pulse_en) begin
      o_pin_out  <= i_pulse_wave; // see R4
      o_pin_oe_n <= 1'h0;
    end else begin
      // Input function does not turn the driver off: software must
      o_pin_out  <= i_port_data;  // see R5 see R9
      o_pin_oe_n <= ~i_port_dir;  // see R6 see R7
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_func_in <= 1'h0;
      o_pin_in  <= 1'h0;
    end else begin
      o_func_in <= i_in_en & i_pin; // see R6 see R7 see R8
      o_pin_in  <= i_pin;           // see R9
    end
  end
endmodule : spf_digital_pin

//--- spf_map.svh
// Register offsets, reset values and pin counts of the pin function select
`ifndef SPF_MAP_SVH
`define SPF_MAP_SVH
`define SPF_ADDR_W        4
`define SPF_DATA_W        16
`define SPF_OFF_CONV1_SEL 4'h0
`define SPF_OFF_CONV2_SEL 4'h1
`define SPF_OFF_PORT_DIR  4'h2
`define SPF_OFF_PORT_DATA 4'h3
`define SPF_OFF_PORT_PIN  4'h4
`define SPF_OFF_FUNC_EN   4'h5
`define SPF_OFF_PIN_STATE 4'h6
`define SPF_CONV1_PINS    4
`define SPF_CONV2_PINS    7
`define SPF_ANALOG_PINS   11
`define SPF_DIG_PINS      6
`define SPF_FUNC_BITS     8
`define SPF_SEL_RESET     16'h0000
`define SPF_FE_PULSE1     0
`define SPF_FE_PULSE2     1
`define SPF_FE_PULSE3     2
`define SPF_FE_IRQ4       3
`define SPF_FE_IRQ5       4
`define SPF_FE_TRIG0      5
`define SPF_FE_TRIG1      6
`define SPF_FE_TRIG2      7
`endif

//--- spf_pin_select.sv
// Top of the shared pin function select for the first pin group
// Contract
// R1: First four analog pins reach converter 1 only while selected.
// R2: Seven further analog pins reach converter 2 only while selected.
// R3: An analog pin not selected works as its port bit.
// R4: Pulse waveform drives its pin only while its output is enabled.
// R5: Pulse/interrupt shared pins are port only when both are disabled.
// R6: Enabled interrupt pin is sampled; software keeps port driver off.
// R7: Enabled trigger pin is sampled; software keeps port driver off.
// R8: Trigger pin returns to port use when its input is disabled.
// R9: Port mode uses direction and data bits; pins always readable. Here the last trigger pin has no port bits and is not in the pin read word.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "spf_map.svh"
module spf_pin_select (
  input  wire logic                        i_clock,
  input  wire logic                        i_rstn,
  input  wire logic [`SPF_ADDR_W-1:0]      i_addr,
  input  wire logic [`SPF_DATA_W-1:0]      i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic      [`SPF_DATA_W-1:0]      o_rdata,
  input  wire logic [`SPF_ANALOG_PINS-1:0] i_analog_pin,
  output logic      [`SPF_ANALOG_PINS-1:0] o_analog_pin,
  output logic      [`SPF_ANALOG_PINS-1:0] o_analog_pin_oe_n,
  output logic      [`SPF_CONV1_PINS-1:0]  o_conv1_conn,
  output logic      [`SPF_CONV2_PINS-1:0]  o_conv2_conn,
  input  wire logic [`SPF_DIG_PINS-1:0]    i_dig_pin,
  output logic      [`SPF_DIG_PINS-1:0]    o_dig_pin,
  output logic      [`SPF_DIG_PINS-1:0]    o_dig_pin_oe_n,
  input  wire logic [2:0]                  i_pulse_wave,
  output logic      [1:0]                  o_ext_irq,
  output logic      [2:0]                  o_reload_trig
);
  logic [`SPF_CONV1_PINS-1:0]  conv1_analog_select;
  logic [`SPF_CONV2_PINS-1:0]  conv2_analog_select;
  logic [`SPF_DATA_W-1:0]      port_dir;
  logic [`SPF_DATA_W-1:0]      port_data;
  logic [`SPF_FUNC_BITS-1:0]   func_en;
  logic [`SPF_ANALOG_PINS-1:0] an_sel;
  logic [`SPF_ANALOG_PINS-1:0] an_in;
  logic [`SPF_ANALOG_PINS-1:0] an_conn;
  logic [`SPF_DIG_PINS-1:0]    dg_in;
  logic [`SPF_DIG_PINS-1:0]    dg_func;
  logic [`SPF_DIG_PINS-1:0]    dg_pulse_en;
  logic [`SPF_DIG_PINS-1:0]    dg_wave;
  logic [`SPF_DIG_PINS-1:0]    dg_in_en;
  logic [`SPF_DIG_PINS-1:0]    dg_dir;
  logic [`SPF_DIG_PINS-1:0]    dg_dat;
  logic [`SPF_DATA_W-1:0]      next_rdata;
  spf_pkg::spf_owner_type      dig0_owner;

  // Word decode, shared by the write and read paths
  function automatic logic hit(input logic [`SPF_ADDR_W-1:0] a,
                               input logic [`SPF_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      conv1_analog_select <= `SPF_CONV1_PINS'(`SPF_SEL_RESET);
      conv2_analog_select <= `SPF_CONV2_PINS'(`SPF_SEL_RESET);
    end else if (i_wr && hit(i_addr, `SPF_OFF_CONV1_SEL)) begin
      conv1_analog_select <= i_wdata[`SPF_CONV1_PINS-1:0];
    end else if (i_wr && hit(i_addr, `SPF_OFF_CONV2_SEL)) begin
      conv2_analog_select <= i_wdata[`SPF_CONV2_PINS-1:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      port_dir  <= `SPF_SEL_RESET;
      port_data <= `SPF_SEL_RESET;
      func_en   <= `SPF_FUNC_BITS'(`SPF_SEL_RESET);
    end else if (i_wr && hit(i_addr, `SPF_OFF_PORT_DIR)) begin
      port_dir  <= i_wdata;
    end else if (i_wr && hit(i_addr, `SPF_OFF_PORT_DATA)) begin
      port_data <= i_wdata;
    end else if (i_wr && hit(i_addr, `SPF_OFF_FUNC_EN)) begin
      func_en   <= i_wdata[`SPF_FUNC_BITS-1:0];
    end
  end

  assign an_sel = {conv2_analog_select, conv1_analog_select};

  genvar g;
  generate
    for (g = 0; g < `SPF_ANALOG_PINS; g++) begin : g_an
      spf_analog_pin u_pin (
        .i_clock       (i_clock),
        .i_rstn        (i_rstn),
        .i_analog_sel  (an_sel[g]),
        .i_port_dir    (port_dir[g]),
        .i_port_data   (port_data[g]),
        .i_pin         (i_analog_pin[g]),
        .o_analog_conn (an_conn[g]),
        .o_pin_out     (o_analog_pin[g]),
        .o_pin_oe_n    (o_analog_pin_oe_n[g]),
        .o_pin_in      (an_in[g])
      );
    end
  endgenerate

  assign o_conv1_conn = an_conn[`SPF_CONV1_PINS-1:0];                 // see R1
  assign o_conv2_conn = an_conn[`SPF_ANALOG_PINS-1:`SPF_CONV1_PINS]; // see R2

  // Digital pins 0..2: pulse outputs 1..3 (0 and 2 share irq 4/5)
  // Digital pins 3..5: reload timer triggers 0..2
  assign dg_pulse_en = {3'h0, func_en[`SPF_FE_PULSE3],
                        func_en[`SPF_FE_PULSE2], func_en[`SPF_FE_PULSE1]};
  assign dg_wave     = {3'h0, i_pulse_wave};
  assign dg_in_en    = {func_en[`SPF_FE_TRIG2], func_en[`SPF_FE_TRIG1],
                        func_en[`SPF_FE_TRIG0], func_en[`SPF_FE_IRQ5],
                        1'h0, func_en[`SPF_FE_IRQ4]};

  // Only five port bits lie above the analog pins, so the last trigger
  // pin has no port driver of its own
  assign dg_dir      = {1'h0, port_dir[`SPF_DATA_W-1:`SPF_ANALOG_PINS]};
  assign dg_dat      = {1'h0, port_data[`SPF_DATA_W-1:`SPF_ANALOG_PINS]};

  generate
    for (g = 0; g < `SPF_DIG_PINS; g++) begin : g_dg
      spf_digital_pin u_pin (
        .i_clock      (i_clock),
        .i_rstn       (i_rstn),
        .i_pulse_en   (dg_pulse_en[g]),
        .i_pulse_wave (dg_wave[g]),
        .i_in_en      (dg_in_en[g]),
        .i_port_dir   (dg_dir[g]),
        .i_port_data  (dg_dat[g]),
        .i_pin        (i_dig_pin[g]),
        .o_pin_out    (o_dig_pin[g]),
        .o_pin_oe_n   (o_dig_pin_oe_n[g]),
        .o_func_in    (dg_func[g]),
        .o_pin_in     (dg_in[g])
      );
    end
  endgenerate

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_ext_irq     <= 2'h0;
      o_reload_trig <= 3'h0;
    end else begin
      o_ext_irq     <= {dg_func[2], dg_func[0]};         // see R6
      o_reload_trig <= dg_func[5:3];                      // see R7 see R8
    end
  end

  // Ownership of the pin shared by pulse 1 and irq 4
  always_comb begin
    if (func_en[`SPF_FE_PULSE1] || func_en[`SPF_FE_IRQ4]) begin
      dig0_owner = spf_pkg::SPF_PERIPH;                   // see R5
    end else begin
      dig0_owner = spf_pkg::SPF_PORT;
    end
  end

  always_comb begin
    next_rdata = `SPF_SEL_RESET;
    case (1'h1)
      hit(i_addr, `SPF_OFF_CONV1_SEL): next_rdata =
        `SPF_DATA_W'(conv1_analog_select);
      hit(i_addr, `SPF_OFF_CONV2_SEL): next_rdata =
        `SPF_DATA_W'(conv2_analog_select);
      hit(i_addr, `SPF_OFF_PORT_DIR):  next_rdata = port_dir;
      hit(i_addr, `SPF_OFF_PORT_DATA): next_rdata = port_data;
      hit(i_addr, `SPF_OFF_PORT_PIN):  next_rdata =
        `SPF_DATA_W'({dg_in, an_in});                      // see R9
      hit(i_addr, `SPF_OFF_FUNC_EN):   next_rdata =
        `SPF_DATA_W'(func_en);
      hit(i_addr, `SPF_OFF_PIN_STATE): next_rdata =
        `SPF_DATA_W'({dig0_owner == spf_pkg::SPF_PORT, an_conn});
      default:                         next_rdata = `SPF_SEL_RESET;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_rdata <= `SPF_SEL_RESET;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= `SPF_SEL_RESET;
    end
  end

  // Pin outputs follow their control bits one clock later, so each check
  // looks back one cycle at the register that steers the pin
  property p_conv1;
    @(posedge i_clock) disable iff (!i_rstn)
    1'h1 |=> (o_conv1_conn == $past(conv1_analog_select));
  endproperty : p_conv1
  a_conv1: assert property (p_conv1) // see R1
    else $error("conv1 connection mismatch");

  property p_conv2;
    @(posedge i_clock) disable iff (!i_rstn)
    1'h1 |=> (o_conv2_conn == $past(conv2_analog_select));
  endproperty : p_conv2
  a_conv2: assert property (p_conv2) // see R2
    else $error("conv2 connection mismatch");

  property p_an_port;
    @(posedge i_clock) disable iff (!i_rstn)
    an_sel[0] |=> o_analog_pin_oe_n[0];
  endproperty : p_an_port
  a_an_port: assert property (p_an_port) // see R3
    else $error("analog pin driven while analog");

  property p_pulse;
    @(posedge i_clock) disable iff (!i_rstn)
    func_en[`SPF_FE_PULSE2] |=> (!o_dig_pin_oe_n[1]
      && o_dig_pin[1] == $past(i_pulse_wave[1]));
  endproperty : p_pulse
  a_pulse: assert property (p_pulse) // see R4
    else $error("pulse not on pin");

  property p_pulse_off;
    @(posedge i_clock) disable iff (!i_rstn)
    !func_en[`SPF_FE_PULSE2] |=>
      (o_dig_pin_oe_n[1] == !$past(port_dir[`SPF_ANALOG_PINS+1])
      && o_dig_pin[1] == $past(port_data[`SPF_ANALOG_PINS+1]));
  endproperty : p_pulse_off
  a_pulse_off: assert property (p_pulse_off) // see R4
    else $error("pulse pin not back to port");

  // The pin shared by pulse 1 and irq 4 is a port bit with both off
  property p_share;
    @(posedge i_clock) disable iff (!i_rstn)
    (!func_en[`SPF_FE_PULSE1] && !func_en[`SPF_FE_IRQ4]) |=>
      (o_dig_pin_oe_n[0] == !$past(port_dir[`SPF_ANALOG_PINS])
      && o_dig_pin[0] == $past(port_data[`SPF_ANALOG_PINS]));
  endproperty : p_share
  a_share: assert property (p_share) // see R5
    else $error("shared pin not port");

  // Interrupt and trigger levels pass the pin flop and the output flop
  sequence s_irq5_high;
    (func_en[`SPF_FE_IRQ5] && i_dig_pin[2]) ##1 1'h1;
  endsequence : s_irq5_high
  property p_irq;
    @(posedge i_clock) disable iff (!i_rstn)
    s_irq5_high |=> o_ext_irq[1];
  endproperty : p_irq
  a_irq: assert property (p_irq) // see R6
    else $error("irq not sampled");

  sequence s_trig1_high;
    (func_en[`SPF_FE_TRIG1] && i_dig_pin[4]) ##1 1'h1;
  endsequence : s_trig1_high
  property p_trig;
    @(posedge i_clock) disable iff (!i_rstn)
    s_trig1_high |=> o_reload_trig[1];
  endproperty : p_trig
  a_trig: assert property (p_trig) // see R7
    else $error("trigger not sampled");

  sequence s_trig0_off;
    (!func_en[`SPF_FE_TRIG0]) [*2];
  endsequence : s_trig0_off
  property p_trig_off;
    @(posedge i_clock) disable iff (!i_rstn)
    s_trig0_off |=> !o_reload_trig[0];
  endproperty : p_trig_off
  a_trig_off: assert property (p_trig_off) // see R8
    else $error("trigger seen while disabled");

  property p_trig_port;
    @(posedge i_clock) disable iff (!i_rstn)
    !func_en[`SPF_FE_TRIG0] |=>
      (o_dig_pin_oe_n[3] == !$past(port_dir[`SPF_ANALOG_PINS+3]));
  endproperty : p_trig_port
  a_trig_port: assert property (p_trig_port) // see R8
    else $error("trigger pin not back to port");

  property p_port;
    @(posedge i_clock) disable iff (!i_rstn)
    (!an_sel[5] && port_dir[5]) |=>
      (!o_analog_pin_oe_n[5] && o_analog_pin[5] == $past(port_data[5]));
  endproperty : p_port
  a_port: assert property (p_port) // see R9
    else $error("port mode wrong");

  property p_pin_read;
    @(posedge i_clock) disable iff (!i_rstn)
    (i_rd && i_addr == `SPF_OFF_PORT_PIN && $past(i_rstn)) |=>
      (o_rdata[`SPF_ANALOG_PINS-1:0] == $past(i_analog_pin, 2));
  endproperty : p_pin_read
  a_pin_read: assert property (p_pin_read) // see R9
    else $error("pin levels not readable");

  property p_rd_idle;
    @(posedge i_clock) disable iff (!i_rstn)
    !i_rd |=> (o_rdata == `SPF_SEL_RESET);
  endproperty : p_rd_idle
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read cycle");
endmodule : spf_pin_select

//--- spf_pkg.sv
// Types shared by the pin function select block
package spf_pkg;
  typedef enum logic [1:0] {
    SPF_PORT   = 2'h1,
    SPF_PERIPH = 2'h2
  } spf_owner_type;
endpackage : spf_pkg

//--- tb_spf_pin_select.sv
// Self-checking testbench of the pin function select
`timescale 1ns/10ps
module tb_spf_pin_select;
  logic        i_clock = 1'b0;
  logic        i_rstn  = 1'b0;
  logic [3:0]  i_addr  = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic        i_wr    = 1'b0;
  logic        i_rd    = 1'b0;
  logic [15:0] o_rdata;
  logic [10:0] apin, aout, aoe_n;
  logic [10:0] alevel  = 11'h000;
  logic [3:0]  c1conn;
  logic [6:0]  c2conn;
  logic [5:0]  dpin, dout, doe_n;
  logic [5:0]  dlevel  = 6'h00;
  logic [2:0]  wave    = 3'h0;
  logic [2:0]  trig;
  logic [1:0]  irq;
  logic        rd_d    = 1'b0;
  logic [31:0] exp_q[$];
  int          n_errors  = 0;
  int          cmp_count = 0;

  always #50 i_clock = ~i_clock;

  spf_pin_select spf_pin_select_inst (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_analog_pin(apin),
    .o_analog_pin(aout), .o_analog_pin_oe_n(aoe_n), .o_conv1_conn(c1conn),
    .o_conv2_conn(c2conn), .i_dig_pin(dpin), .o_dig_pin(dout),
    .o_dig_pin_oe_n(doe_n), .i_pulse_wave(wave), .o_ext_irq(irq),
    .o_reload_trig(trig));

  spf_board spf_board_inst (
    .i_apin_out(aout), .i_apin_oe_n(aoe_n), .i_dpin_out(dout),
    .i_dpin_oe_n(doe_n), .i_alevel(alevel), .i_dlevel(dlevel),
    .o_apin(apin), .o_dpin(dpin));

  task automatic check(string name, logic [15:0] got, logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", name, exp, got);
    end
  endtask : check

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  // One idle cycle after each strobe keeps drivers single per time step
  task automatic wr(logic [3:0] a, logic [15:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
    @(posedge i_clock);
  endtask : wr

  task automatic rd(logic [3:0] a, logic [15:0] e, logic [15:0] m);
    exp_q.push_back({m, e & m});
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(posedge i_clock);
  endtask : rd

  // Read data stand only in the cycle after the read strobe
  always @(posedge i_clock) begin
    rd_d <= i_rd;
    if (rd_d) begin
      check("rdata", o_rdata & exp_q[0][31:16], exp_q[0][15:0]);
      void'(exp_q.pop_front());
    end
  end

  initial begin
    #(100 * 20000);
    n_errors++;
    print_verdict();
  end

  initial begin
    logic [15:0] c1, c2, dir, dat, fe;
    logic [4:0]  eoe, eout;
    logic [10:0] aoe, alv;
    logic [5:0]  lvl;
    logic        pe, ie, te;
    void'($urandom(4336));
    repeat (8) @(posedge i_clock);
    i_rstn <= 1'b1;
    @(posedge i_clock);
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), (a == 6) ? 16'h0800 : 16'h0000, (a == 6) ? 16'h0FFF : 16'hFFFF);
    end
    $display("test reset done");
    for (int it = 0; it < 12; it++) begin
      c1 = 16'($urandom) & 16'h000F;
      c2 = 16'($urandom) & 16'h007F;
      fe = 16'($urandom) & 16'h00FF;
      dir = 16'($urandom);
      dat = 16'($urandom);
      // Port driver kept off on pins whose trigger or irq input is enabled
      dir[15:14] = dir[15:14] & ~fe[6:5];
      dir[11] = dir[11] & ~fe[3];
      dir[13] = dir[13] & ~fe[4];
      wave <= 3'($urandom);
      alevel <= 11'($urandom);
      dlevel <= 6'($urandom);
      wr(4'h0, c1);
      wr(4'h1, c2);
      wr(4'h2, dir);
      wr(4'h3, dat);
      wr(4'h5, fe);
      repeat (4) @(posedge i_clock);
      for (int p = 0; p < 5; p++) begin
        pe = (p < 3) && fe[p];
        ie = (p == 0 && fe[3]) || (p == 2 && fe[4]);
        te = (p > 2) && fe[p + 2];
        eoe[p] = pe ? 1'b0 : (ie || te) ? 1'b1 : ~dir[11 + p];
        eout[p] = pe ? wave[p] : dat[11 + p];
        lvl[p] = eoe[p] ? dlevel[p] : eout[p];
      end
      lvl[5] = dlevel[5];
      check("conv1", c1conn, c1);
      check("conv2", c2conn, c2);
      aoe = ~dir[10:0] | {c2[6:0], c1[3:0]};
      alv = (aoe & alevel) | (~aoe & dat[10:0]);
      check("aoe_n", aoe_n, aoe);
      check("aout", aout & ~aoe, dat[10:0] & ~aoe);
      check("doe_n", doe_n, {1'b1, eoe});
      check("dout", dout[4:0] & ~eoe, eout & ~eoe);
      check("irq", irq, {lvl[2], lvl[0]} & fe[4:3]);
      check("trig", trig, lvl[5:3] & fe[7:5]);
      rd(4'h0, c1, 16'hFFFF);
      rd(4'h1, c2, 16'hFFFF);
      rd(4'h2, dir, 16'hFFFF);
      rd(4'h3, dat, 16'hFFFF);
      rd(4'h4, {lvl[4:0], alv}, 16'hFFFF);
      rd(4'h5, fe, 16'hFFFF);
      rd(4'h6, {4'h0, ~fe[0] & ~fe[3], c2[6:0], c1[3:0]}, 16'h0FFF);
      $display("test random %0d done", it);
    end
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_clock);
    check("conv1 after reset", c1conn, 16'h0000);
    check("aoe_n after reset", aoe_n, 16'h07FF);
    $display("test mid-run reset done");
    repeat (3) @(posedge i_clock);
    print_verdict();
  end
endmodule : tb_spf_pin_select
